// ===== verilog/gdcsr_pkg.sv
package gdcsr_pkg;

  // Register select codes on the register access port
  localparam logic [1:0] SEL_TIMING_CFG = 2'h0;
  localparam logic [1:0] SEL_SUPPLY_STAT = 2'h1;
  localparam logic [1:0] SEL_FAULT_STAT = 2'h2;

  // Field layout of driver_timing_config
  localparam int DT_LSB = 2;
  localparam int DT_W = 3;
  localparam int BLANK_LSB = 0;
  localparam int BLANK_W = 2;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Bit positions in ldo_gate_fault_status
  localparam int LDO5_UV_BIT = 5;
  localparam int BOR_WARN_BIT = 4;
  localparam int OC_FAULT_BIT = 3;
  localparam int GATE_UV_BIT = 2;
  localparam logic BOR_WARN_RESET = 1'b1;

  // Status flag input widths
  localparam int SUPPLY_W = 8;
  localparam int FLAG_W = 11;

  // Timing figures in ns and clock period
  localparam int CLK_PERIOD_NS = 20;
  localparam int DT_MAX_NS = 2000;
  localparam int DT_STEP_NS = 250;
  localparam int BLANK_MAX_NS = 4000;
  localparam int CNT_W = 8;

  // Dead-time cycles, rounded up as a least time
  function automatic logic [CNT_W-1:0] dt_cycles(input logic [DT_W-1:0] code);
    int ns;
    ns = DT_MAX_NS - int'(code) * DT_STEP_NS;
    return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : dt_cycles

  // Blanking cycles, halving per code step
  function automatic logic [CNT_W-1:0] blank_cycles(input logic [BLANK_W-1:0] code);
    int ns;
    ns = BLANK_MAX_NS >> code;
    return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : blank_cycles

  // Gate phase states
  typedef enum logic [3:0] {
    ST_LOW = 4'b0001,
    ST_DEAD_UP = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_DEAD_DOWN = 4'b1000
  } gdcsr_state_type;

endpackage : gdcsr_pkg

// ===== verilog/gdcsr_sync.sv
`timescale 1ns/1ns
module gdcsr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gdcsr_sync_state_type;

  gdcsr_sync_state_type s_q;
  gdcsr_sync_state_type s_d;

  // Two-stage chain; first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.stage1 = async_in;
    s_d.stage2 = s_q.stage1;
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage2;

endmodule : gdcsr_sync

// ===== verilog/gdcsr_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// [RULE_01] Bits 4:2 set opposing-drive gap, 250ns steps
// [RULE_02] Codes 000..111 give 2000 down to 250ns
// [RULE_03] Bits 1:0 blanking: 4000,2000,1000,500 ns
// [RULE_04] Bits 7:5 read zero, writes ignored
// [RULE_05] Status0 bit 6 shows buck low warning
// [RULE_06] All status flags synchronised before reading
module gdcsr_regs (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [gdcsr_pkg::SUPPLY_W-1:0] supply_flags_in,
  input wire logic ldo5_uv_in,
  input wire logic gate_uv_in,
  input wire logic overcurrent_in,
  input wire logic pwm_in,
  output logic high_gate_out,
  output logic low_gate_out,
  output logic blank_active_out,
  output logic oc_fault_out
);
  import gdcsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Status flag synchronisation

  logic [FLAG_W-1:0] flags_sync;
  logic [SUPPLY_W-1:0] supply_sync;
  logic ldo5_sync;
  logic gate_uv_sync;
  logic oc_sync;

  // Every external flag passes two flops first
  // Flags are levels, so a late capture only costs one cycle
  gdcsr_sync #(
    .WIDTH(FLAG_W)
  ) u_flag_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .async_in({overcurrent_in, gate_uv_in, ldo5_uv_in, supply_flags_in}),
    .sync_out(flags_sync)
  ); // [RULE_06]

  // Split synchronised flags
  assign supply_sync = flags_sync[SUPPLY_W-1:0];
  assign ldo5_sync = flags_sync[SUPPLY_W];
  assign gate_uv_sync = flags_sync[SUPPLY_W+1];
  assign oc_sync = flags_sync[SUPPLY_W+2];

  ////////////////////////////////////////////////////////////////////////////
  // Block state

  typedef struct packed {
    gdcsr_state_type st;
    logic [CNT_W-1:0] dt_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic [CFG_W-1:0] cfg;
    logic bor_warn;
    logic high;
    logic low;
    logic blank;
    logic oc;
    logic [7:0] rdata;
    logic rvalid;
  } gdcsr_core_type;

  gdcsr_core_type c_q;
  gdcsr_core_type c_d;

  logic [DT_W-1:0] dt_code;
  logic [BLANK_W-1:0] blank_code;
  logic [CNT_W-1:0] dt_len;
  logic [CNT_W-1:0] blank_len;
  logic [7:0] fault_word;
  logic cfg_write;
  logic gate_on;

  // Field decode and cycle lengths
  assign dt_code = c_q.cfg[DT_LSB +: DT_W];
  assign blank_code = c_q.cfg[BLANK_LSB +: BLANK_W];
  assign dt_len = dt_cycles(dt_code); // [RULE_01] [RULE_02]
  assign blank_len = blank_cycles(blank_code); // [RULE_03]
  assign cfg_write = reg_wr_in && (reg_sel_in == SEL_TIMING_CFG);

  // Fault status word, unimplemented bits zero
  // Overcurrent bit uses the blank-qualified flop, matching the pin
  always_comb begin
    fault_word = 8'h00;
    fault_word[LDO5_UV_BIT] = ldo5_sync;
    fault_word[BOR_WARN_BIT] = c_q.bor_warn;
    fault_word[OC_FAULT_BIT] = c_q.oc;
    fault_word[GATE_UV_BIT] = gate_uv_sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    c_d = c_q;
    gate_on = 1'b0;

    // Only the five implemented bits store
    if (cfg_write) begin
      c_d.cfg = reg_wdata_in[CFG_W-1:0]; // [RULE_04]
      c_d.bor_warn = 1'b0;
    end

    // Dead-time insertion between opposing drives
    // Gap length is latched at gap start; a config write mid-gap waits
    // A reversal inside the gap returns to the old side at once
    case (c_q.st)
      ST_LOW: begin
        if (pwm_in) begin
          c_d.st = ST_DEAD_UP;
          c_d.low = 1'b0;
          c_d.dt_cnt = dt_len - 8'h01; // [RULE_01]
        end
      end
      ST_DEAD_UP: begin
        if (!pwm_in) begin
          c_d.st = ST_LOW;
          c_d.low = 1'b1;
          gate_on = 1'b1;
        end else if (c_q.dt_cnt == 8'h00) begin
          c_d.st = ST_HIGH;
          c_d.high = 1'b1;
          gate_on = 1'b1;
        end else begin
          c_d.dt_cnt = c_q.dt_cnt - 8'h01;
        end
      end
      ST_HIGH: begin
        if (!pwm_in) begin
          c_d.st = ST_DEAD_DOWN;
          c_d.high = 1'b0;
          c_d.dt_cnt = dt_len - 8'h01; // [RULE_01]
        end
      end
      ST_DEAD_DOWN: begin
        if (pwm_in) begin
          c_d.st = ST_HIGH;
          c_d.high = 1'b1;
          gate_on = 1'b1;
        end else if (c_q.dt_cnt == 8'h00) begin
          c_d.st = ST_LOW;
          c_d.low = 1'b1;
          gate_on = 1'b1;
        end else begin
          c_d.dt_cnt = c_q.dt_cnt - 8'h01;
        end
      end
      default: begin
        c_d.st = ST_LOW;
        c_d.high = 1'b0;
        c_d.low = 1'b1;
      end
    endcase

    // Blanking window after each gate turn-on
    if (gate_on) begin
      c_d.blank = 1'b1;
      c_d.blank_cnt = blank_len - 8'h01; // [RULE_03]
    end else if (c_q.blank) begin
      if (c_q.blank_cnt == 8'h00) begin
        c_d.blank = 1'b0;
      end else begin
        c_d.blank_cnt = c_q.blank_cnt - 8'h01;
      end
    end

    // Overcurrent ignored while blanking
    c_d.oc = oc_sync && !c_q.blank; // [RULE_03]

    // Register read, answered one cycle later
    // Same-cycle write and read returns the old config
    c_d.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_sel_in)
        SEL_TIMING_CFG: c_d.rdata = {3'h0, c_q.cfg}; // [RULE_04]
        SEL_SUPPLY_STAT: c_d.rdata = supply_sync; // [RULE_05] [RULE_06]
        SEL_FAULT_STAT: c_d.rdata = fault_word; // [RULE_06]
        default: c_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      c_q.st <= ST_LOW;
      c_q.dt_cnt <= 8'h00;
      c_q.blank_cnt <= 8'h00;
      c_q.cfg <= CFG_RESET;
      c_q.bor_warn <= BOR_WARN_RESET;
      c_q.high <= 1'b0;
      c_q.low <= 1'b1;
      c_q.blank <= 1'b0;
      c_q.oc <= 1'b0;
      c_q.rdata <= 8'h00;
      c_q.rvalid <= 1'b0;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_out = c_q.rdata;
  assign reg_rvalid_out = c_q.rvalid;
  assign high_gate_out = c_q.high;
  assign low_gate_out = c_q.low;
  assign blank_active_out = c_q.blank;
  assign oc_fault_out = c_q.oc;

endmodule : gdcsr_regs

// ===== verif/gdcsr_host.sv
`timescale 1ns/1ns
// Host side of the register port
module gdcsr_host (
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_out,
  output logic rd_out,
  output logic [1:0] sel_out,
  output logic [7:0] wdata_out
);
  // Idle port at time zero
  initial begin
    {wr_out, rd_out, sel_out, wdata_out} = 12'h000;
  end
  // One strobed access; released lines carry inverted junk
  task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk_in);
    {wr_out, rd_out, sel_out, wdata_out} = {w, !w, s, d};
    @(negedge mclk_in);
    {wr_out, rd_out, sel_out, wdata_out} = {2'h0, ~s, ~d};
    q = rvalid_in ? rdata_in : 8'hxx; // Missing valid shows as unknown
  endtask : acc
endmodule : gdcsr_host

// ===== verif/gdcsr_checker.sv
`timescale 1ns/1ns
// Port-level checks of the timing register and gate link
module gdcsr_checker (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [gdcsr_pkg::SUPPLY_W-1:0] supply_flags_in,
  input wire logic high_gate_out,
  input wire logic low_gate_out,
  input wire logic blank_active_out,
  input wire logic oc_fault_out
);
  import gdcsr_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic [4:0] cfg_q;
  logic low_last_q;
  logic [7:0] gap_q;
  logic [7:0] blk_q;
  int dt_len;
  int bl_len;
  // Expected gap and window lengths in cycles, rounded up
  assign dt_len = (DT_MAX_NS - DT_STEP_NS * int'(cfg_q[4:2]) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  assign bl_len = ((BLANK_MAX_NS >> cfg_q[1:0]) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Shadow of timing fields, last gate side, run lengths
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {cfg_q, low_last_q, gap_q, blk_q} <= {5'h00, 1'h1, 16'h0000};
    end else begin
      if (reg_wr_in && reg_sel_in == SEL_TIMING_CFG) cfg_q <= reg_wdata_in[4:0];
      if (high_gate_out || low_gate_out) low_last_q <= low_gate_out;
      gap_q <= (high_gate_out || low_gate_out) ? 8'h00 : gap_q + 8'h01;
      blk_q <= blank_active_out ? blk_q + 8'h01 : 8'h00;
    end
  end
  sequence s_rd(logic [1:0] s);
    reg_rd_in && !reg_wr_in && reg_sel_in == s;
  endsequence
  sequence s_steady;
    (!srst_in && $stable(supply_flags_in[6]))[*4];
  endsequence
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read got no valid");
  a_cfg_top: assert property (s_rd(SEL_TIMING_CFG) |=> reg_rdata_out[7:5] == 3'h0)
    else $error("config top bits not zero");
  a_cfg_write: assert property ((reg_wr_in && !reg_rd_in && reg_sel_in == SEL_TIMING_CFG) ##1 !reg_wr_in ##1
    s_rd(SEL_TIMING_CFG) |=> reg_rdata_out == {3'h0, $past(reg_wdata_in[4:0], 3)})
    else $error("config readback wrong");
  a_buck_warn: assert property (s_steady ##0 s_rd(SEL_SUPPLY_STAT)
    |=> reg_rdata_out[6] == $past(supply_flags_in[6])) else $error("buck warning wrong");
  a_gap_len: assert property (($rose(high_gate_out) && low_last_q) ||
    ($rose(low_gate_out) && !low_last_q) |-> gap_q == dt_len) else $error("dead gap length wrong");
  a_blank_len: assert property ($fell(blank_active_out) |-> blk_q == bl_len)
    else $error("blanking length wrong");
  a_oc_masked: assert property (blank_active_out |=> !oc_fault_out)
    else $error("fault seen while blanking");
  a_no_overlap: assert property (!(high_gate_out && low_gate_out))
    else $error("both gates on");
endmodule : gdcsr_checker
bind gdcsr_regs gdcsr_checker chk_u (.mclk_in(mclk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .supply_flags_in(supply_flags_in), .high_gate_out(high_gate_out),
  .low_gate_out(low_gate_out), .blank_active_out(blank_active_out), .oc_fault_out(oc_fault_out));

// ===== verif/test_gate_driver_cfg_status_regs.sv
`timescale 1ns/1ns
// Self-checking bench for the timing config and status bank
module test_gate_driver_cfg_status_regs;
  import gdcsr_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic pwm = 1'b0;
  logic ldo5 = 1'b0;
  logic guv = 1'b0;
  logic oc = 1'b0;
  logic [7:0] sup = 8'h00;
  logic wr, rd, rv, hi, lo, bl, ocf;
  logic [1:0] sel;
  logic [7:0] wd, rdat, q, d;
  int failures = 0;
  int num_checks = 0;
  always #10 mclk_in = ~mclk_in;
  gdcsr_regs dut_u (.mclk_in(mclk_in), .srst_in(srst_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_sel_in(sel),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .supply_flags_in(sup), .ldo5_uv_in(ldo5),
    .gate_uv_in(guv), .overcurrent_in(oc), .pwm_in(pwm), .high_gate_out(hi), .low_gate_out(lo),
    .blank_active_out(bl), .oc_fault_out(ocf));
  gdcsr_host host_u (.mclk_in(mclk_in), .rdata_in(rdat), .rvalid_in(rv), .wr_out(wr), .rd_out(rd),
    .sel_out(sel), .wdata_out(wd));
  // Compare one byte
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // A used-up wait bound ends the run
  task automatic bound(input int k);
    if (k >= 400) begin
      failures++;
      report_and_stop();
    end
  endtask : bound
  // Swing the phase demand, time the new gate, let blanking end
  task automatic swing(input logic v, input int c);
    int k;
    @(negedge mclk_in);
    pwm = v;
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while ((v ? hi : lo) !== 1'b1 && k < 400);
    bound(k);
    chk("gap", 8'((DT_MAX_NS - DT_STEP_NS * c + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1), 8'(k));
    k = 0;
    while (bl !== 1'b0 && k < 400) begin
      @(negedge mclk_in);
      k++;
    end
    bound(k);
  endtask : swing
  // Main sequence
  initial begin
    d = 8'($urandom(32'h0000_4c18));
    repeat (12) @(negedge mclk_in);
    srst_in = 1'b0;
    host_u.acc(1'b0, SEL_TIMING_CFG, 8'h00, q);
    chk("cfg reset", 8'h00, q);
    host_u.acc(1'b0, SEL_FAULT_STAT, 8'h00, q);
    chk("fault reset", 8'h10, q);
    host_u.acc(1'b1, SEL_SUPPLY_STAT, 8'hff, q);
    host_u.acc(1'b0, 2'h3, 8'h00, q);
    chk("unmapped", 8'h00, q);
    host_u.acc(1'b0, SEL_TIMING_CFG, 8'h00, q);
    chk("cfg after refused", 8'h00, q);
    for (int c = 0; c < 32; c++) begin
      d = {3'($urandom), 5'(c)};
      oc = 1'($urandom);
      host_u.acc(1'b1, SEL_TIMING_CFG, d, q);
      host_u.acc(1'b0, SEL_TIMING_CFG, 8'h00, q);
      chk("cfg", {3'h0, d[4:0]}, q);
      swing(1'b1, c / 4);
      swing(1'b0, c / 4);
    end
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? (i == 1 ? 8'hbf : 8'h40) : 8'($urandom);
      {ldo5, guv, oc} = 3'($urandom);
      sup = d;
      repeat (3) @(negedge mclk_in);
      chk("oc out", {7'h00, oc}, {7'h00, ocf});
      host_u.acc(1'b0, SEL_SUPPLY_STAT, 8'h00, q);
      chk("supply", d, q);
      host_u.acc(1'b0, SEL_FAULT_STAT, 8'h00, q);
      chk("fault", {2'h0, ldo5, 1'h0, oc, guv, 2'h0}, q);
    end
    report_and_stop();
  end
endmodule : test_gate_driver_cfg_status_regs
